//--- pkg/srtam_params.svh
// Constants of the SDRAM refresh timer and address multiplexer.
// Assumes a 32-bit classic Wishbone slave on a single 100 MHz clock.
//
// Contract
// - Set compare-match flag, bit 7 of timer control/status, when counter equals constant.
// - Writing 0 clears the compare-match flag; writing 1 leaves it unchanged.
// - Clock select: 000 stops; 001..111 divide bus clock by 4..4096.
// - Control/status bits 15:8 read zero; writes to them are discarded.
// - Refresh counter is a 16-bit software read/write up-counter on prescaled ticks.
// - Reset clears refresh counter, refresh constant and timer control/status.
// - Refresh enabled in auto mode starts a refresh cycle on every match.
// - Refresh constant is compared continuously with the counter's lower 8 bits; the code compares only on prescaler ticks.
// - Bank config: base in 15:8 resets 0x20, mask resets 0xf8.
// - Bank config bits 31:16 read zero; writes to them have no effect.
// - SDRAM address driven on A14..A0 with row/column muxed internally.
// - Mux arrangement chosen by column width, row width and bank-count bit.
// - Column phase: A0-A9 = bits 11:2, A10 level bit, A11/A12 = bits 12/13.
// - Row phase: 13-bit slice starting at bit 10 plus column width offset.
// - Bank bits A13/A14 start at 21/22 and shift per added column or row bit.
// - One bank select uses only A13; two use A13 and A14.
// - A10 in column phase follows the access mode of the issued command.

`ifndef SRTAM_PARAMS_SVH
`define SRTAM_PARAMS_SVH

// =====================================================================
// Register byte addresses
`define SRTAM_ADR_MCTL      32'h1301_0080
`define SRTAM_ADR_CSR       32'h1301_0084
`define SRTAM_ADR_CNT       32'h1301_0088
`define SRTAM_ADR_CONST     32'h1301_008c
`define SRTAM_ADR_BANK      32'h1301_0090

// =====================================================================
// Reset values
`define SRTAM_RST_MCTL      8'h00
`define SRTAM_RST_CSR       16'h0000
`define SRTAM_RST_CNT       16'h0000
`define SRTAM_RST_CONST     16'h0000
`define SRTAM_RST_BASE      8'h20
`define SRTAM_RST_MASK      8'hf8

// =====================================================================
// Field positions
`define SRTAM_CSR_FLAG_BIT  7
`define SRTAM_BANK_BASE_LSB 8
`define SRTAM_CMP_W         8

// =====================================================================
// Prescale divide, as log2 of the ratio per select code 1..7
`define SRTAM_LOG_DIV1      4'd2
`define SRTAM_LOG_DIV2      4'd4
`define SRTAM_LOG_DIV3      4'd6
`define SRTAM_LOG_DIV4      4'd8
`define SRTAM_LOG_DIV5      4'd10
`define SRTAM_LOG_DIV6      4'd11
`define SRTAM_LOG_DIV7      4'd12

// =====================================================================
// Address mux slice origins
`define SRTAM_COL_LSB       2
`define SRTAM_ROW_LSB       10
`define SRTAM_BANK_LSB      21

`endif

//--- pkg/srtam_pkg.sv
// Types shared by the refresh timer and address multiplexer.
// Assumes the constants header is compiled alongside.
package srtam_pkg;

    // =================================================================
    // Memory control fields that this block consumes
    typedef struct packed {
        logic       refresh_enable;
        logic       refresh_mode_select;  // 0 auto-refresh, 1 self-refresh
        logic       bank_count;           // 0 one bank select, 1 two
        logic [1:0] row_width_field;      // 0..2 -> 11..13 bits
        logic [2:0] column_width_field;   // 0..4 -> 8..12 bits
    } srtam_mctl_t;

    // Bank region configuration
    typedef struct packed {
        logic [7:0] base;
        logic [7:0] mask;
    } srtam_bank_t;

endpackage

//--- logic/srtam_prescaler.sv
// Prescaler that turns the bus clock into refresh counter ticks.
// Assumes it runs on the same clock as the counter it feeds.
`timescale 1ns/1ns
`include "srtam_params.svh"

module srtam_prescaler #(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Select and tick
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);

    logic [DIV_W-1:0] div_reg;
    logic [3:0]       log_div;
    logic [DIV_W-1:0] div_mask;

    // Largest ratio must fit the divider
    initial begin
        if (DIV_W < 12) begin
            $error("srtam_prescaler: DIV_W must be at least 12");
        end
    end

    // Ratio lookup; code 0 gates the clock off
    always_comb begin
        case (sel_i)
            3'h1:    log_div = `SRTAM_LOG_DIV1;
            3'h2:    log_div = `SRTAM_LOG_DIV2;
            3'h3:    log_div = `SRTAM_LOG_DIV3;
            3'h4:    log_div = `SRTAM_LOG_DIV4;
            3'h5:    log_div = `SRTAM_LOG_DIV5;
            3'h6:    log_div = `SRTAM_LOG_DIV6;
            3'h7:    log_div = `SRTAM_LOG_DIV7;
            default: log_div = 4'h0;
        endcase
        div_mask = DIV_W'((1 << log_div) - 1);
    end

    // Free divider, held at zero while stopped so restart is clean
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && sel_i == 3'h0)) begin
            div_reg <= '0;
        end else if (ce_i) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign tick_o = ce_i && (sel_i != 3'h0) && ((div_reg & div_mask) == div_mask);

endmodule // srtam_prescaler

//--- logic/srtam_top.sv
// Refresh timer, bank decoder and row/column address mux for SDRAM.
// Assumes a classic Wishbone master and same-clock address inputs.
`timescale 1ns/1ns
`include "srtam_params.svh"

module srtam_top
    import srtam_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Access request from the sequencer
    input  wire logic [31:0] phys_addr_i,
    input  wire logic        row_phase_i,
    input  wire logic        level_bit_i,
    // SDRAM side
    output logic [14:0]      sdram_addr_o,
    output logic             bank_sel_o,
    output logic             refresh_start_o,
    output logic             compare_match_o
);

    // =================================================================
    // Elaboration checks
    // Only the 16-bit counter is served
    initial begin
        if (CNT_W != 16) begin
            $error("srtam_top: refresh counter must be 16 bits");
        end
        // Compare slice must fit the counter
        if (`SRTAM_CMP_W > CNT_W) begin
            $error("srtam_top: compare width too wide");
        end
    end

    // =================================================================
    // Declarations
    // Software-visible registers
    srtam_mctl_t         mctl_reg;
    srtam_bank_t         bank_reg;
    logic [2:0]          clk_sel_reg;
    logic                flag_reg;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic [15:0]         const_reg;

    // Bus decode and answer
    logic [31:0]         rdata_next;
    logic [31:0]         wmask;
    logic                ack_reg;
    logic                req;
    logic                wr;
    logic                hit_mctl;
    logic                hit_csr;
    logic                hit_cnt;
    logic                hit_const;
    logic                hit_bank;
    logic                cnt_wr;

    // Timer datapath
    logic                tick;
    logic                match;
    logic                flag_clr;

    // Address mux datapath
    logic [3:0]          col_add;
    logic [3:0]          row_add;
    logic [31:0]         row_slice;
    logic [31:0]         bank_slice;
    logic [14:0]         addr_next;

    // Output flops
    logic                refresh_reg;
    logic                bank_sel_reg;
    logic [14:0]         addr_reg;

    // =================================================================
    // Bus decode
    // A request is taken on one edge; ack_reg blocks a second take for
    // one cycle only, so a cyc/stb held high is taken again every second cycle.
    // Full 32-bit decode, no aliases.
    assign req       = cyc_i && stb_i && !ack_reg && ce_i;
    assign wr        = req && we_i;
    assign hit_mctl  = (adr_i == `SRTAM_ADR_MCTL);
    assign hit_csr   = (adr_i == `SRTAM_ADR_CSR);
    assign hit_cnt   = (adr_i == `SRTAM_ADR_CNT);
    assign hit_const = (adr_i == `SRTAM_ADR_CONST);
    assign hit_bank  = (adr_i == `SRTAM_ADR_BANK);

    // Strobes shared by several processes
    assign cnt_wr    = wr && hit_cnt;
    assign flag_clr  = wr && hit_csr && sel_i[0] && !dat_i[`SRTAM_CSR_FLAG_BIT];

    // Byte lane mask from the select lines
    // Bytes with select low keep their value
    always_comb begin
        wmask = '0;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{sel_i[i]}};
        end
    end

    // =================================================================
    // Bus answer
    // Ack follows the taken request by one edge and drops the next;
    // unmapped addresses are acked too, reading zero, so a stray
    // access never hangs the bus.
    // With ce_i low the answer waits too;
    // the master sees that as wait states.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
        end
    end

    // Read mux; reserved bits come back as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_mctl) begin
            rdata_next[7:0] = mctl_reg;
        end
        if (hit_csr) begin
            rdata_next[`SRTAM_CSR_FLAG_BIT] = flag_reg;
            rdata_next[2:0] = clk_sel_reg;
        end
        if (hit_cnt) begin
            rdata_next[15:0] = cnt_reg;
        end
        if (hit_const) begin
            rdata_next[15:0] = const_reg;
        end
        if (hit_bank) begin
            rdata_next[15:0] = bank_reg;
        end
    end

    // Read data latched with the answer
    // and held until the next request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req) begin
            dat_o <= rdata_next;
        end
    end

    // Answer straight from its flop
    assign ack_o = ack_reg;

    // =================================================================
    // Memory control fields used here
    // Low byte only; the rest lives elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mctl_reg <= `SRTAM_RST_MCTL;
        end else if (wr && hit_mctl && sel_i[0]) begin
            mctl_reg <= dat_i[7:0];
        end
    end

    // =================================================================
    // Bank region register; upper half is not stored at all
    // Base and mask follow their byte lanes;
    // with both lanes low nothing changes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_reg.base <= `SRTAM_RST_BASE;
            bank_reg.mask <= `SRTAM_RST_MASK;
        end else if (wr && hit_bank) begin
            if (sel_i[1]) begin
                bank_reg.base <= dat_i[`SRTAM_BANK_BASE_LSB +: 8];
            end
            if (sel_i[0]) begin
                bank_reg.mask <= dat_i[7:0];
            end
        end
    end

    // =================================================================
    // Timer control/status: clock select field
    // Bits 15:8 are not stored at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_reg <= 3'(`SRTAM_RST_CSR);
        end else if (wr && hit_csr && sel_i[0]) begin
            clk_sel_reg <= dat_i[2:0];
        end
    end

    // Compare-match flag; a match in the clearing cycle wins, so no
    // event is lost to a racing software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (match) begin
                flag_reg <= 1'b1;
            end else if (flag_clr) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // =================================================================
    // Prescaler
    // Non-zero code changes keep the phase, so
    // a first tick may be early; go via code 0.
    srtam_prescaler #(
        .DIV_W (12)
    ) u_prescaler (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .sel_i  (clk_sel_reg),
        .tick_o (tick)
    );

    // =================================================================
    // Counter and compare
    // Only the low byte of the count is compared, so the interval is
    // at most 256 ticks; the upper constant byte is storage only.
    // Seen only on a tick, so a write never fires it.
    assign match = tick &&
        (cnt_reg[`SRTAM_CMP_W-1:0] == const_reg[`SRTAM_CMP_W-1:0]);

    // A software write beats a tick in the same cycle
    // A count whose low byte is past the constant's runs until that byte wraps
    always_comb begin
        cnt_next = cnt_reg;
        if (cnt_wr) begin
            cnt_next = (cnt_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        end else if (match) begin
            cnt_next = '0;
        end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Counter, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= `SRTAM_RST_CNT;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end

    // Refresh constant
    // Upper byte is kept but never compared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            const_reg <= `SRTAM_RST_CONST;
        end else if (wr && hit_const) begin
            const_reg <= (const_reg & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        end
    end

    // =================================================================
    // Refresh start: a one-cycle request to the command sequencer
    // Self-refresh mode sets the flag only;
    // its entry belongs to the sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_reg <= 1'b0;
        end else if (ce_i) begin
            refresh_reg <= match && mctl_reg.refresh_enable
                           && !mctl_reg.refresh_mode_select;
        end
    end

    // Both pins straight from flops
    assign refresh_start_o = refresh_reg;
    assign compare_match_o = flag_reg;

    // =================================================================
    // Bank region decode
    // Overlapping regions are the software's problem; this decoder
    // only answers for its own region.
    // Only the top address byte takes part.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_sel_reg <= 1'b0;
        end else if (ce_i) begin
            bank_sel_reg <= ((phys_addr_i[31:24] & bank_reg.mask)
                             == (bank_reg.base & bank_reg.mask));
        end
    end

    // Select pin straight from its flop
    assign bank_sel_o = bank_sel_reg;

    // =================================================================
    // Row/column address mux
    // Every added column bit moves the row slice up by one; every added
    // column or row bit moves the bank bits up by one.
    // Reserved width codes just shift further.
    assign col_add    = {1'b0, mctl_reg.column_width_field};
    assign row_add    = {2'b00, mctl_reg.row_width_field};
    assign row_slice  = phys_addr_i >> (`SRTAM_ROW_LSB + col_add);
    assign bank_slice = phys_addr_i >> (`SRTAM_BANK_LSB + col_add + row_add);

    always_comb begin
        addr_next = 15'h0000;
        if (row_phase_i) begin
            addr_next[12:0] = row_slice[12:0];
        end else begin
            addr_next[9:0]  = phys_addr_i[`SRTAM_COL_LSB +: 10];
            addr_next[10]   = level_bit_i;
            addr_next[12:11] = phys_addr_i[13:12];
        end

        // Bank bits in both phases
        addr_next[13] = bank_slice[0];
        addr_next[14] = mctl_reg.bank_count ? bank_slice[1] : 1'b0;
    end

    // Pins always carry a defined value, idle or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= 15'h0000;
        end else if (ce_i) begin
            addr_reg <= addr_next;
        end
    end

    // Address pins straight from their flops
    assign sdram_addr_o = addr_reg;

endmodule // srtam_top

//--- verification/srtam_props.sv
// Port checker for the refresh timer, bank decoder and address mux.
// Assumes one clock, synchronous reset and a classic Wishbone master.
`timescale 1ns/1ns
`include "srtam_params.svh"

module srtam_props #(
    parameter int CNT_W = 16
) (
    // Clock, reset, enable
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // Wishbone slave
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        we_i,
    input wire logic [3:0]  sel_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Access request
    input wire logic [31:0] phys_addr_i,
    input wire logic        row_phase_i,
    input wire logic        level_bit_i,
    // SDRAM side
    input wire logic [14:0] sdram_addr_o,
    input wire logic        bank_sel_o,
    input wire logic        refresh_start_o,
    input wire logic        compare_match_o
);
    // =================================================================
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // =================================================================
    // Bus handshake
    ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
    csr_rsvd_a: assert property (ack_o && !we_i && adr_i == `SRTAM_ADR_CSR |-> dat_o[31:8] == 24'h0)
        else $error("status reserved bits not zero");
    bank_rsvd_a: assert property (ack_o && !we_i && adr_i == `SRTAM_ADR_BANK |-> dat_o[31:16] == 16'h0)
        else $error("bank config upper half not zero");

    // =================================================================
    // Refresh timer; a set flag survives until a write reaches it
    flag_hold_a: assert property (compare_match_o && !(cyc_i && stb_i && we_i) |=> compare_match_o)
        else $error("flag dropped without a write");
    refresh_flag_a: assert property (refresh_start_o |-> compare_match_o ##1 !refresh_start_o)
        else $error("refresh pulse without flag or too long");
    reset_clear_a: assert property ($fell(rst_i) |-> !compare_match_o && !refresh_start_o && sdram_addr_o == 15'h0)
        else $error("outputs not cleared by reset");

    // =================================================================
    // Column phase address mux, one cycle behind its inputs
    col_map_a: assert property (ce_i && !row_phase_i |=> sdram_addr_o[12:0] ==
        {$past(phys_addr_i[13:12]), $past(level_bit_i), $past(phys_addr_i[11:2])}) else $error("column map wrong");
    level_a: assert property (ce_i && !row_phase_i && level_bit_i |=> sdram_addr_o[10])
        else $error("level bit lost");
endmodule // srtam_props

bind srtam_top srtam_props #(.CNT_W(CNT_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i),
    .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .phys_addr_i(phys_addr_i), .row_phase_i(row_phase_i), .level_bit_i(level_bit_i), .sdram_addr_o(sdram_addr_o),
    .bank_sel_o(bank_sel_o), .refresh_start_o(refresh_start_o), .compare_match_o(compare_match_o));

//--- verification/srtam_sdram_model.sv
// Model of an SDRAM chip capturing row, column and bank from its pins.
// Assumes the bench strobes commands only while the pins are settled.
`timescale 1ns/1ns

module srtam_sdram_model (
    // Clock
    input wire logic        clk_i,
    // Pins seen by the chip
    input wire logic [14:0] sdram_addr_i,
    input wire logic        chip_sel_i,
    input wire logic        act_i,
    input wire logic        col_i,
    // Captured fields
    output logic [12:0]     row_o,
    output logic [12:0]     col_o,
    output logic [1:0]      bank_o
);
    // =================================================================
    // Capture; a deselected chip ignores commands, like real parts
    always_ff @(posedge clk_i) begin
        if (chip_sel_i && act_i) begin
            row_o <= sdram_addr_i[12:0];
        end
        if (chip_sel_i && col_i) begin
            col_o <= sdram_addr_i[12:0];
        end
        if (chip_sel_i && (act_i || col_i)) begin
            bank_o <= sdram_addr_i[14:13];
        end
    end
endmodule // srtam_sdram_model

//--- verification/srtam_top_tb_top.sv
// Self-checking bench for the refresh timer, bank decoder and mux.
// Assumes the checker binds itself; bus per classic Wishbone.
`timescale 1ns/1ns
`include "srtam_params.svh"

module srtam_top_tb_top
    import srtam_pkg::*;
;
    logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
    logic        row_phase_i = 1'h0, level_bit_i = 1'h0, act = 1'h0, colc = 1'h0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, phys_addr_i = 32'h0, dat_o, rdat, pa;
    logic [3:0]  sel_i = 4'hf;
    logic [14:0] sdram_addr_o;
    logic        ack_o, bank_sel_o, refresh_start_o, compare_match_o;
    logic [12:0] m_row, m_col;
    logic [1:0]  m_bank;
    int          error_cnt = 0, checks_done = 0, cyc_cnt = 0, n;
    int          dv[7] = '{4, 16, 64, 256, 1024, 2048, 4096};

    // =================================================================
    // Design and chip model
    srtam_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i),
        .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .phys_addr_i(phys_addr_i),
        .row_phase_i(row_phase_i), .level_bit_i(level_bit_i), .sdram_addr_o(sdram_addr_o),
        .bank_sel_o(bank_sel_o), .refresh_start_o(refresh_start_o), .compare_match_o(compare_match_o));
    srtam_sdram_model u_chip (.clk_i(clk_i), .sdram_addr_i(sdram_addr_o), .chip_sel_i(bank_sel_o), .act_i(act),
        .col_i(colc), .row_o(m_row), .col_o(m_col), .bank_o(m_bank));

    // Clock and hang guard; the prescaler sweep dominates the run
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 90000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    end

    // =================================================================
    // Shared tasks
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; waits for ack, one idle cycle after
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
        adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1'h1; stb_i <= 1'h1;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        rdat = dat_o;
        cyc_i <= 1'h0; stb_i <= 1'h0; we_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        wb(a, 1'h0, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic wait_pulse();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (refresh_start_o !== 1'h1 && n < 200);
    endtask
    task automatic bsel(input logic [31:0] a, input logic exp);
        phys_addr_i <= a;
        repeat (2) @(posedge clk_i);
        chk({31'h0, bank_sel_o}, {31'h0, exp});
    endtask
    // Drive a phase, then strobe the chip once the pins have settled
    task automatic mux_cycle(input logic rp);
        row_phase_i <= rp;
        @(posedge clk_i);
        act <= rp; colc <= !rp;
        @(posedge clk_i);
        act <= 1'h0; colc <= 1'h0;
        @(posedge clk_i);
    endtask

    // =================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        rchk(`SRTAM_ADR_MCTL, 32'h0);
        rchk(`SRTAM_ADR_CSR, 32'h0);
        rchk(`SRTAM_ADR_CNT, 32'h0);
        rchk(`SRTAM_ADR_CONST, 32'h0);
        rchk(`SRTAM_ADR_BANK, 32'h20f8);
        wb(32'h1301_00a0, 1'h1, 32'hffff_ffff);
        rchk(32'h1301_00a0, 32'h0);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'hffff_ff80);
        rchk(`SRTAM_ADR_CSR, 32'h0);
        wb(`SRTAM_ADR_CNT, 1'h1, 32'h1234);
        repeat (50) @(posedge clk_i);
        rchk(`SRTAM_ADR_CNT, 32'h1234);
        // Each select code counts about four ticks in four divide periods
        wb(`SRTAM_ADR_CONST, 1'h1, 32'hff);
        for (int c = 1; c < 8; c++) begin
            wb(`SRTAM_ADR_CSR, 1'h1, 32'h0);
            wb(`SRTAM_ADR_CNT, 1'h1, 32'h0);
            wb(`SRTAM_ADR_CSR, 1'h1, c);
            repeat (dv[c-1] * 4) @(posedge clk_i);
            wb(`SRTAM_ADR_CNT, 1'h0, 32'h0);
            chk({31'h0, rdat >= 3 && rdat <= 5}, 32'h1);
        end
        // Match on the low byte only, auto refresh, restart from zero
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h0);
        wb(`SRTAM_ADR_CNT, 1'h1, 32'h0);
        wb(`SRTAM_ADR_CONST, 1'h1, 32'h0102);
        wb(`SRTAM_ADR_MCTL, 1'h1, 32'h80);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h1);
        wait_pulse();
        chk({31'h0, n < 200}, 32'h1);
        wait_pulse();
        chk(n, 12);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h80);
        rchk(`SRTAM_ADR_CSR, 32'h80);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h0);
        rchk(`SRTAM_ADR_CSR, 32'h0);
        // Self-refresh mode: flag sets but no refresh cycle starts
        wb(`SRTAM_ADR_MCTL, 1'h1, 32'hc0);
        wb(`SRTAM_ADR_CNT, 1'h1, 32'h0);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h1);
        repeat (40) begin
            @(posedge clk_i);
            chk({31'h0, refresh_start_o}, 32'h0);
        end
        chk({31'h0, compare_match_o}, 32'h1);
        rchk(`SRTAM_ADR_CSR, 32'h81);
        wb(`SRTAM_ADR_CSR, 1'h1, 32'h0);
        // Bank decode with reset and programmed regions
        bsel(32'h2500_0000, 1'h1);
        bsel(32'h2800_0000, 1'h0);
        wb(`SRTAM_ADR_BANK, 1'h1, 32'hffff_40c0);
        rchk(`SRTAM_ADR_BANK, 32'h40c0);
        bsel(32'h7f00_0000, 1'h1);
        bsel(32'hbf00_0000, 1'h0);
        // Clock enable low freezes the decoder
        ce_i <= 1'h0;
        phys_addr_i <= 32'h7f00_0000;
        repeat (3) @(posedge clk_i);
        chk({31'h0, bank_sel_o}, 32'h0);
        ce_i <= 1'h1;
        // Mux over every width and bank count, with an all-open region
        wb(`SRTAM_ADR_BANK, 1'h1, 32'h0);
        for (int bc = 0; bc < 2; bc++) begin
            for (int cw = 0; cw < 5; cw++) begin
                for (int rw = 0; rw < 3; rw++) begin
                    wb(`SRTAM_ADR_MCTL, 1'h1, bc * 32 + rw * 8 + cw);
                    for (int p = 0; p < 2; p++) begin
                        pa = p ? 32'hfa59_3c26 : 32'h05a6_c3d9;
                        phys_addr_i <= pa;
                        level_bit_i <= p;
                        mux_cycle(1'h1);
                        chk(m_row, (pa >> (10 + cw)) & 32'h1fff);
                        chk(m_bank, {bc ? pa[22+cw+rw] : 1'h0, pa[21+cw+rw]});
                        mux_cycle(1'h0);
                        chk(m_col, {pa[13:12], p[0], pa[11:2]});
                        chk(m_bank, {bc ? pa[22+cw+rw] : 1'h0, pa[21+cw+rw]});
                    end
                end
            end
        end
        give_verdict();
    end
endmodule // srtam_top_tb_top
